//--- core/flash_prot_pkg.sv
package flash_prot_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int STATUS_WRITE_NS = 200;
    localparam int STATUS_WRITE_CYC_RAW = (STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STATUS_WRITE_CYC = (STATUS_WRITE_CYC_RAW < 1) ? 1 : STATUS_WRITE_CYC_RAW;
    localparam int TIMER_W = 8;

    // ------------------------------------------------------------
    // serial commands
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_NONE = 8'h00;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // ------------------------------------------------------------
    // array map
    // ------------------------------------------------------------
    localparam int ADDR_W = 25;
    localparam int SECTOR_W = 9;
    localparam int SUB32_W = 10;
    localparam int SUB4_W = 13;
    localparam int SECTOR_LSB = 16;
    localparam int SUB32_LSB = 15;
    localparam int SUB4_LSB = 12;
    localparam logic [ADDR_W-1:0] LAST_ADDR = 25'h1ff_ffff;
    localparam logic [SECTOR_W:0] NUM_SECTORS = 10'h200;
    localparam logic [3:0] BP_NONE = 4'h0;
    localparam logic [3:0] BP_ALL_FROM = 4'ha;
    localparam logic [SECTOR_W:0] ONE_SECTOR = 10'h001;

    // ------------------------------------------------------------
    // register layout, bit 7 down to bit 0
    // ------------------------------------------------------------
    typedef struct packed {
        logic srwd;
        logic bp3;
        logic tb;
        logic [2:0] bp_lo;
        logic wel;
        logic wip;
    } status_reg_t;

    localparam status_reg_t SR_RESET = 8'h00;

    typedef enum logic [2:0] {
        OP_PROGRAM,
        OP_ERASE_4K,
        OP_ERASE_32K,
        OP_ERASE_64K,
        OP_BULK
    } op_kind_t;

    typedef struct packed {
        logic valid;
        op_kind_t kind;
        logic [ADDR_W-1:0] addr;
    } op_req_t;

    typedef struct packed {
        logic go;
        op_kind_t kind;
        logic [ADDR_W-1:0] addr;
        logic [SECTOR_W-1:0] sector;
        logic [SUB32_W-1:0] sub32;
        logic [SUB4_W-1:0] sub4;
    } array_cmd_t;

    typedef struct packed {
        logic rx_strobe;
        logic first;
        logic [7:0] rx_byte;
        logic frame_end;
    } link_evt_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SR_WRITE,
        ST_ARRAY_BUSY
    } core_fsm_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [SECTOR_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:SECTOR_LSB];
    endfunction

    function automatic logic [SUB32_W-1:0] sub32_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:SUB32_LSB];
    endfunction

    function automatic logic [SUB4_W-1:0] sub4_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:SUB4_LSB];
    endfunction

    function automatic logic [3:0] bp_of(input status_reg_t s);
        return {s.bp3, s.bp_lo};
    endfunction

endpackage

//--- core/serial_link_rx.sv
module serial_link_rx (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    input wire logic [7:0] i_tx_byte,
    output flash_prot_pkg::link_evt_t o_evt,
    output logic o_miso,
    output logic o_miso_oe
);

    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_d;
        logic cs_s1;
        logic cs_s2;
        logic cs_d;
        logic mosi_s1;
        logic mosi_s2;
        logic [7:0] shift;
        logic [2:0] bitcnt;
        logic first_pend;
        logic [7:0] tx;
        logic miso;
        logic oe;
        flash_prot_pkg::link_evt_t evt;
    } link_state_t;

    link_state_t q_ff;
    link_state_t nxt_q;
    logic active;
    logic sclk_rise;
    logic sclk_fall;

    // ------------------------------------------------------------
    // edge finding and shifting
    // ------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;
        nxt_q.sclk_s1 = i_sclk;
        nxt_q.sclk_s2 = q_ff.sclk_s1;
        nxt_q.sclk_d = q_ff.sclk_s2;
        nxt_q.cs_s1 = i_cs_n;
        nxt_q.cs_s2 = q_ff.cs_s1;
        nxt_q.cs_d = q_ff.cs_s2;
        nxt_q.mosi_s1 = i_mosi;
        nxt_q.mosi_s2 = q_ff.mosi_s1;
        nxt_q.evt.rx_strobe = 1'b0;
        nxt_q.evt.frame_end = 1'b0;
        active = !q_ff.cs_s2;
        sclk_rise = q_ff.sclk_s2 && !q_ff.sclk_d;
        sclk_fall = !q_ff.sclk_s2 && q_ff.sclk_d;
        if (!q_ff.cs_s2 && q_ff.cs_d) begin
            nxt_q.bitcnt = 3'h0;
            nxt_q.first_pend = 1'b1;
            nxt_q.oe = 1'b1;
        end else if (q_ff.cs_s2 && !q_ff.cs_d) begin
            nxt_q.evt.frame_end = 1'b1;
            nxt_q.oe = 1'b0;
            nxt_q.bitcnt = 3'h0;
        end else if (active && sclk_rise) begin
            nxt_q.shift = {q_ff.shift[6:0], q_ff.mosi_s2};
            nxt_q.bitcnt = q_ff.bitcnt + 3'h1;
            if (q_ff.bitcnt == flash_prot_pkg::BIT_LAST) begin
                nxt_q.evt.rx_strobe = 1'b1;
                nxt_q.evt.rx_byte = {q_ff.shift[6:0], q_ff.mosi_s2};
                nxt_q.evt.first = q_ff.first_pend;
                nxt_q.first_pend = 1'b0;
            end
        end else if (active && sclk_fall) begin
            if (q_ff.bitcnt == 3'h0) begin
                nxt_q.miso = i_tx_byte[7];
                nxt_q.tx = {i_tx_byte[6:0], 1'b0};
            end else begin
                nxt_q.miso = q_ff.tx[7];
                nxt_q.tx = {q_ff.tx[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q_ff <= '0;
            q_ff.sclk_s1 <= 1'b0;
            q_ff.cs_s1 <= 1'b1;
            q_ff.cs_s2 <= 1'b1;
            q_ff.cs_d <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign o_evt = q_ff.evt;
    assign o_miso = q_ff.miso;
    assign o_miso_oe = q_ff.oe;

    AST_OE_ENDS_WITH_FRAME: assert property (
        @(posedge i_clk) disable iff (i_rst)
        q_ff.evt.frame_end |-> !o_miso_oe ##1 !o_miso_oe
    ) else $error("read data still driven after frame end");

endmodule // serial_link_rx

//--- core/block_protect_decode.sv
module block_protect_decode (
    input wire logic i_tb,
    input wire logic [3:0] i_bp,
    input wire logic [flash_prot_pkg::SECTOR_W-1:0] i_sector,
    input wire logic i_bulk,
    output logic o_hit
);

    logic [flash_prot_pkg::SECTOR_W:0] count;
    logic [flash_prot_pkg::SECTOR_W:0] sec_wide;

    // ------------------------------------------------------------
    // protected range from top or bottom
    // ------------------------------------------------------------
    always_comb begin
        count = '0;
        sec_wide = {1'b0, i_sector};
        if (i_bp != flash_prot_pkg::BP_NONE && i_bp < flash_prot_pkg::BP_ALL_FROM) begin
            count = flash_prot_pkg::ONE_SECTOR << (i_bp - 4'h1);
        end
        if (i_bulk) begin
            o_hit = (i_bp != flash_prot_pkg::BP_NONE);
        end else if (i_bp == flash_prot_pkg::BP_NONE) begin
            o_hit = 1'b0;
        end else if (i_bp >= flash_prot_pkg::BP_ALL_FROM) begin
            o_hit = 1'b1;
        end else if (!i_tb) begin
            o_hit = (sec_wide >= flash_prot_pkg::NUM_SECTORS - count);
        end else begin
            o_hit = (sec_wide < count);
        end
    end

endmodule // block_protect_decode

//--- core/flash_status_block_protect.sv
// Notes on behaviour
// - host reads and writes status over serial
// - lock bit plus low pin blocks writes
// - only raising pin, reset or a running status write clearing bit 7 releases hardware lock
// - bit 7 disables status writes while pin low, default 0
// - bit 5 picks top or bottom area
// - protect bits refuse program/erase in area
// - write latch clear at reset, needs enable
// - bit 0 busy during write/program/erase
// - bulk erase only when protect bits zero
// - busy bit inverse of flag ready
// - top: uppermost 2^(n-1) sectors protected
// - bottom: lowest 2^(n-1) sectors protected
// - map addresses to sectors and subsectors
module flash_status_block_protect (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    input wire logic i_write_protect_n,
    input flash_prot_pkg::op_req_t i_op,
    input wire logic i_array_done,
    output logic o_miso,
    output logic o_miso_oe,
    output logic o_op_ready,
    output logic o_op_reject,
    output flash_prot_pkg::array_cmd_t o_array,
    output flash_prot_pkg::status_reg_t o_status,
    output logic o_flag_ready
);

    typedef struct packed {
        logic wp_s1;
        logic wp_s2;
        flash_prot_pkg::status_reg_t sr;
        flash_prot_pkg::core_fsm_t st;
        logic [7:0] opcode;
        logic [7:0] wr_data;
        logic wr_have;
        logic [flash_prot_pkg::TIMER_W-1:0] timer;
        flash_prot_pkg::array_cmd_t arr;
        logic reject;
    } core_state_t;

    localparam int SR_BOUND = flash_prot_pkg::STATUS_WRITE_CYC + 2;

    core_state_t q_ff;
    core_state_t nxt_q;
    flash_prot_pkg::link_evt_t evt;
    flash_prot_pkg::status_reg_t wr_val;
    logic hw_lock;
    logic op_take;
    logic prot_hit;
    logic wrsr_try;

    // ------------------------------------------------------------
    // serial link and protection decode
    // ------------------------------------------------------------
    serial_link_rx u_link (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_mosi(i_mosi),
        .i_tx_byte(q_ff.sr),
        .o_evt(evt),
        .o_miso(o_miso),
        .o_miso_oe(o_miso_oe)
    );

    block_protect_decode u_decode (
        .i_tb(q_ff.sr.tb),
        .i_bp(flash_prot_pkg::bp_of(q_ff.sr)),
        .i_sector(flash_prot_pkg::sector_of(i_op.addr)),
        .i_bulk(i_op.kind == flash_prot_pkg::OP_BULK),
        .o_hit(prot_hit)
    );

    // ------------------------------------------------------------
    // status register and operation control
    // ------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;
        nxt_q.wp_s1 = i_write_protect_n;
        nxt_q.wp_s2 = q_ff.wp_s1;
        nxt_q.arr.go = 1'b0;
        nxt_q.reject = 1'b0;
        wr_val = flash_prot_pkg::status_reg_t'(q_ff.wr_data);
        hw_lock = q_ff.sr.srwd && !q_ff.wp_s2;
        o_op_ready = (q_ff.st == flash_prot_pkg::ST_IDLE) && !evt.frame_end;
        op_take = i_op.valid && o_op_ready;
        wrsr_try = evt.frame_end && (q_ff.st == flash_prot_pkg::ST_IDLE)
            && (q_ff.opcode == flash_prot_pkg::CMD_WRITE_STATUS) && q_ff.wr_have;

        if (evt.rx_strobe) begin
            if (evt.first) begin
                nxt_q.opcode = evt.rx_byte;
                nxt_q.wr_have = 1'b0;
            end else if (q_ff.opcode == flash_prot_pkg::CMD_WRITE_STATUS && !q_ff.wr_have
                && q_ff.st != flash_prot_pkg::ST_SR_WRITE) begin
                nxt_q.wr_data = evt.rx_byte;
                nxt_q.wr_have = 1'b1;
            end
        end

        case (q_ff.st)
            flash_prot_pkg::ST_IDLE: begin
                if (evt.frame_end) begin
                    nxt_q.opcode = flash_prot_pkg::CMD_NONE;
                    case (q_ff.opcode)
                        flash_prot_pkg::CMD_WRITE_ENABLE: begin
                            nxt_q.sr.wel = 1'b1;
                        end
                        flash_prot_pkg::CMD_WRITE_DISABLE: begin
                            nxt_q.sr.wel = 1'b0;
                        end
                        flash_prot_pkg::CMD_WRITE_STATUS: begin
                            if (q_ff.wr_have && q_ff.sr.wel) begin
                                if (hw_lock) begin
                                    nxt_q.sr.wel = 1'b0;
                                end else begin
                                    nxt_q.st = flash_prot_pkg::ST_SR_WRITE;
                                    nxt_q.sr.wip = 1'b1;
                                    nxt_q.timer = flash_prot_pkg::TIMER_W'(
                                        flash_prot_pkg::STATUS_WRITE_CYC - 1);
                                end
                            end
                        end
                        default: begin
                        end
                    endcase
                end else if (op_take) begin
                    if (!q_ff.sr.wel || prot_hit) begin
                        nxt_q.reject = 1'b1;
                        nxt_q.sr.wel = 1'b0;
                    end else begin
                        nxt_q.arr.go = 1'b1;
                        nxt_q.arr.kind = i_op.kind;
                        nxt_q.arr.addr = i_op.addr;
                        nxt_q.arr.sector = flash_prot_pkg::sector_of(i_op.addr);
                        nxt_q.arr.sub32 = flash_prot_pkg::sub32_of(i_op.addr);
                        nxt_q.arr.sub4 = flash_prot_pkg::sub4_of(i_op.addr);
                        nxt_q.sr.wip = 1'b1;
                        nxt_q.st = flash_prot_pkg::ST_ARRAY_BUSY;
                    end
                end
            end
            flash_prot_pkg::ST_SR_WRITE: begin
                if (evt.frame_end) begin
                    nxt_q.opcode = flash_prot_pkg::CMD_NONE;
                end
                if (q_ff.timer == '0) begin
                    nxt_q.sr.srwd = wr_val.srwd;
                    nxt_q.sr.bp3 = wr_val.bp3;
                    nxt_q.sr.tb = wr_val.tb;
                    nxt_q.sr.bp_lo = wr_val.bp_lo;
                    nxt_q.sr.wel = 1'b0;
                    nxt_q.sr.wip = 1'b0;
                    nxt_q.st = flash_prot_pkg::ST_IDLE;
                end else begin
                    nxt_q.timer = q_ff.timer - 1'b1;
                end
            end
            flash_prot_pkg::ST_ARRAY_BUSY: begin
                if (evt.frame_end) begin
                    nxt_q.opcode = flash_prot_pkg::CMD_NONE;
                end
                if (i_array_done) begin
                    nxt_q.sr.wip = 1'b0;
                    nxt_q.sr.wel = 1'b0;
                    nxt_q.st = flash_prot_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_q.st = flash_prot_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q_ff <= '0;
            q_ff.sr <= flash_prot_pkg::SR_RESET;
            q_ff.st <= flash_prot_pkg::ST_IDLE;
            q_ff.opcode <= flash_prot_pkg::CMD_NONE;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_status = q_ff.sr;
    assign o_array = q_ff.arr;
    assign o_op_reject = q_ff.reject;
    assign o_flag_ready = !q_ff.sr.wip;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_FLAG_TRACKS_BUSY: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_status.wip) |-> !o_flag_ready && $past(o_flag_ready)
    ) else $error("flag ready not inverse of busy");

    AST_WEL_CLEAR_AFTER_RESET: assert property (
        @(posedge i_clk)
        $past(i_rst) && !i_rst |-> !o_status.wel && !o_status.wip
    ) else $error("write latch or busy set after reset");

    AST_GO_NEEDS_WEL: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_array.go |-> $past(o_status.wel) && !$past(o_status.wip)
    ) else $error("operation started without write latch");

    AST_LOCK_IGNORES_WRITE: assert property (
        @(posedge i_clk) disable iff (i_rst)
        wrsr_try && hw_lock |=> $stable(o_status[7:2]) && !o_status.wip
            && q_ff.st == flash_prot_pkg::ST_IDLE
    ) else $error("status write ran while locked");

    AST_LOCK_HOLDS: assert property (
        @(posedge i_clk) disable iff (i_rst)
        q_ff.st == flash_prot_pkg::ST_IDLE && hw_lock |=> $stable(o_status[7:2])
    ) else $error("locked status bits changed");

    AST_SR_WRITE_ENDS: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $rose(q_ff.st == flash_prot_pkg::ST_SR_WRITE) |-> o_status.wip
            ##[1:SR_BOUND] !o_status.wip
    ) else $error("status write busy window wrong");

    AST_BUSY_WHILE_ARRAY: assert property (
        @(posedge i_clk) disable iff (i_rst)
        q_ff.st == flash_prot_pkg::ST_ARRAY_BUSY |-> o_status.wip && !o_flag_ready
    ) else $error("busy not set during array operation");

    AST_BULK_NEEDS_CLEAR: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_array.go && o_array.kind == flash_prot_pkg::OP_BULK
            |-> flash_prot_pkg::bp_of(o_status) == flash_prot_pkg::BP_NONE
    ) else $error("bulk erase with protect bits set");

    AST_PROTECTED_REFUSED: assert property (
        @(posedge i_clk) disable iff (i_rst)
        op_take && prot_hit |=> o_op_reject && !o_array.go && !o_status.wel
    ) else $error("protected operation not refused");

    AST_TOP_HALF: assert property (
        @(posedge i_clk) disable iff (i_rst)
        i_op.valid && !q_ff.sr.tb && flash_prot_pkg::bp_of(q_ff.sr) == 4'h9
            && i_op.kind != flash_prot_pkg::OP_BULK
            |-> prot_hit == i_op.addr[flash_prot_pkg::ADDR_W-1]
    ) else $error("top selection range wrong");

    AST_BOTTOM_HALF: assert property (
        @(posedge i_clk) disable iff (i_rst)
        i_op.valid && q_ff.sr.tb && flash_prot_pkg::bp_of(q_ff.sr) == 4'h9
            && i_op.kind != flash_prot_pkg::OP_BULK
            |-> prot_hit == !i_op.addr[flash_prot_pkg::ADDR_W-1]
    ) else $error("bottom selection range wrong");

    AST_MAP_NESTED: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_array.go |-> o_array.sub32[9:1] == o_array.sector
            && o_array.sub4[12:3] == o_array.sub32
    ) else $error("subsector numbering inconsistent");

    AST_WEL_DROPS: assert property (
        @(posedge i_clk) disable iff (i_rst)
        q_ff.st == flash_prot_pkg::ST_ARRAY_BUSY && i_array_done
            |=> !o_status.wel && !o_status.wip && o_op_ready
    ) else $error("write latch kept after operation");

    AST_REJECT_CLEARS_WEL: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_op_reject |-> !o_status.wel && !o_array.go && !o_status.wip
    ) else $error("write latch kept after refused operation");

    AST_SR_WRITE_NEEDS_WEL: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $rose(q_ff.st == flash_prot_pkg::ST_SR_WRITE)
            |-> $past(o_status.wel) && !$past(hw_lock)
    ) else $error("status write started without latch or while locked");

    AST_BUSY_BLOCKS_OPS: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_status.wip |-> !o_op_ready
    ) else $error("operation accepted while busy");

    AST_UNLOCK_BY_PIN: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $fell(hw_lock) && $past(q_ff.st) == flash_prot_pkg::ST_IDLE |-> q_ff.wp_s2
    ) else $error("hardware lock left without pin high");

    AST_SR_LOADS_DATA: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $fell(q_ff.st == flash_prot_pkg::ST_SR_WRITE)
            |-> o_status[7:2] == $past(q_ff.wr_data[7:2]) && !o_status.wel
    ) else $error("status write did not load its data");

    AST_OP_ANSWERED: assert property (
        @(posedge i_clk) disable iff (i_rst)
        op_take |=> o_array.go != o_op_reject
    ) else $error("request not answered exactly once");

endmodule // flash_status_block_protect

//--- tb/flash_host_model.sv
module flash_host_model (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso,
    input wire logic i_miso_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // serial clock stands low between frames
    // ------------------------------------------------------------
    localparam real HALF_NS = 62.5;

    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end

    // ------------------------------------------------------------
    // one frame: opcode then data bytes, msb first, mode 0
    // ------------------------------------------------------------
    task automatic frame(input logic [7:0] op, input logic [7:0] dat, input int nbytes,
                         output logic [7:0] rd);
        logic [7:0] tx;
        rd = 8'h00;
        #(HALF_NS / 2);
        o_cs_n = 1'b0;
        #(HALF_NS);
        for (int b = 0; b < nbytes; b++) begin
            tx = (b == 0) ? op : dat;
            for (int i = 7; i >= 0; i--) begin
                o_mosi = tx[i];
                #(HALF_NS);
                o_sclk = 1'b1;
                rd[i] = i_miso_oe ? i_miso : ~rd[i];
                #(HALF_NS);
                o_sclk = 1'b0;
            end
        end
        #(HALF_NS);
        o_cs_n = 1'b1;
        // deselected: data line no longer holds the last bit
        o_mosi = ~o_mosi;
        #(HALF_NS);
    endtask
endmodule // flash_host_model

//--- tb/flash_status_block_protect_test.sv
module flash_status_block_protect_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic i_clk, i_rst, sclk, cs_n, mosi, i_write_protect_n, i_array_done;
    logic o_miso, o_miso_oe, o_op_ready, o_op_reject, o_flag_ready;
    flash_prot_pkg::op_req_t i_op;
    flash_prot_pkg::array_cmd_t o_array;
    flash_prot_pkg::status_reg_t o_status;
    int err_count = 0;
    int cmp_count = 0;
    logic [7:0] rd;
    logic [3:0] bps [4] = '{4'h1, 4'h9, 4'ha, 4'hf};
    logic [8:0] secs [5] = '{9'h000, 9'h0ff, 9'h100, 9'h1fe, 9'h1ff};

    flash_status_block_protect dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_mosi(mosi), .i_write_protect_n(i_write_protect_n), .i_op(i_op),
        .i_array_done(i_array_done), .o_miso(o_miso), .o_miso_oe(o_miso_oe),
        .o_op_ready(o_op_ready), .o_op_reject(o_op_reject), .o_array(o_array),
        .o_status(o_status), .o_flag_ready(o_flag_ready));

    flash_host_model host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(o_miso),
        .i_miso_oe(o_miso_oe));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input int n);
        host_u.frame(op, dat, n, rd);
        repeat (8) @(posedge i_clk);
    endtask

    task automatic wsr(input logic [7:0] v, input logic busy, input logic [7:0] exp);
        cmd(flash_prot_pkg::CMD_WRITE_ENABLE, 8'h00, 1);
        chk(32'(o_status.wel), 32'h1);
        cmd(flash_prot_pkg::CMD_WRITE_STATUS, v, 2);
        chk(32'(o_status.wip), 32'(busy));
        chk(32'(o_flag_ready), 32'(!busy));
        repeat (30) @(posedge i_clk);
        chk(32'(o_status), 32'(exp));
        cmd(flash_prot_pkg::CMD_READ_STATUS, 8'h00, 2);
        chk(32'(rd), 32'(exp));
    endtask

    task automatic op(input logic [2:0] kind, input logic [8:0] s, input logic en,
                      input logic acc);
        logic [24:0] a;
        a = {s, 16'hf123};
        cmd(en ? flash_prot_pkg::CMD_WRITE_ENABLE : flash_prot_pkg::CMD_WRITE_DISABLE, 8'h00, 1);
        @(posedge i_clk);
        i_op <= '{1'b1, flash_prot_pkg::op_kind_t'(kind), a};
        @(negedge i_clk);
        chk(32'(o_op_ready), 32'h1);
        @(posedge i_clk);
        i_op.valid <= 1'b0;
        #1;
        chk(32'(o_array.go), 32'(acc));
        chk(32'(o_op_reject), 32'(!acc));
        if (acc) begin
            chk({o_array.sector, o_array.sub32, o_array.sub4}, {a[24:16], a[24:15], a[24:12]});
            chk(32'({o_array.kind, o_array.addr}), 32'({kind, a}));
            chk(32'(o_status.wip), 32'h1);
            @(posedge i_clk);
            i_array_done <= 1'b1;
            @(posedge i_clk);
            i_array_done <= 1'b0;
        end
        repeat (2) @(posedge i_clk);
        chk(32'(o_status[1:0]), 32'h0);
    endtask

    function automatic logic prot(input logic t, input logic [3:0] bp, input logic [8:0] s);
        int c;
        if (bp == 4'h0) return 1'b0;
        if (bp >= 4'ha) return 1'b1;
        c = 1 << (bp - 1);
        return t ? (int'(s) < c) : (int'(s) >= 512 - c);
    endfunction

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        i_rst <= 1'b1;
        i_write_protect_n <= 1'b1;
        i_array_done <= 1'b0;
        i_op <= '0;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        chk(32'(o_status), 32'(flash_prot_pkg::SR_RESET));
        chk(32'(o_flag_ready), 32'h1);
        op(3'h0, 9'h000, 1'b0, 1'b0);
        op(3'h4, 9'h000, 1'b1, 1'b1);
        for (int t = 0; t < 2; t++) begin
            for (int j = 0; j < 4; j++) begin
                wsr({1'b0, bps[j][3], t[0], bps[j][2:0], 2'b00}, 1'b1,
                    {1'b0, bps[j][3], t[0], bps[j][2:0], 2'b00});
                for (int k = 0; k < 5; k++) begin
                    op(3'(k % 4), secs[k], 1'b1, !prot(t[0], bps[j], secs[k]));
                end
                op(3'h4, 9'h000, 1'b1, 1'b0);
            end
        end
        wsr(8'h80, 1'b1, 8'h80);
        @(posedge i_clk);
        i_write_protect_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        wsr(8'h00, 1'b0, 8'h80);
        @(posedge i_clk);
        i_write_protect_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        wsr(8'h00, 1'b1, 8'h00);
        cmd(flash_prot_pkg::CMD_WRITE_ENABLE, 8'h00, 1);
        chk(32'(o_status.wel), 32'h1);
        i_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        #1;
        chk(32'(o_status), 32'(flash_prot_pkg::SR_RESET));
        summarize;
    end

    initial begin
        #400000;
        err_count++;
        summarize;
    end
endmodule // flash_status_block_protect_test
